/* core/tah_pkg.sv */
// Package: parameter numbers, field positions, reset values and states of the drive control
package tah_pkg;

	// ********************************
	// Parameter numbers on the link
	// ********************************
	localparam logic [7:0] PAR_SAVE       = 8'h11;
	localparam logic [7:0] PAR_STATUS     = 8'h14;
	localparam logic [7:0] PAR_SERVO_CMD  = 8'h1E;
	localparam logic [7:0] PAR_CTRL_MODE  = 8'h1F;
	localparam logic [7:0] PAR_TRQ_SEL    = 8'h4C;
	localparam logic [7:0] PAR_HOME_TYPE  = 8'h5A;
	localparam logic [7:0] PAR_PRESET     = 8'h5B;
	localparam logic [7:0] PAR_HOME_DIR   = 8'h5C;
	localparam logic [7:0] PAR_HOME_SPD   = 8'h5D;
	localparam logic [7:0] PAR_CREEP_SPD  = 8'h5E;
	localparam logic [7:0] PAR_THRUST_MS  = 8'h5F;
	localparam logic [7:0] PAR_THRUST_TRQ = 8'h60;
	localparam logic [7:0] PAR_IN_SET0    = 8'h64;
	localparam logic [7:0] PAR_CUR_SCALE  = 8'h83;
	localparam logic [7:0] PAR_AIN_OFS    = 8'h84;

	// ********************************
	// Field positions and codes
	// ********************************
	localparam int          SC_SERVO_ON    = 0;
	localparam int          SC_OFS_MEAS    = 4;
	localparam int          SC_HOME_ARM    = 13;
	localparam int          POL_BIT        = 7;
	localparam int          IN_NEG_BIT     = 7;
	localparam int          NUM_IN         = 6;
	localparam logic [15:0] MODE_TORQUE    = 16'h0003;
	localparam logic [15:0] MODE_HOME      = 16'h0004;
	localparam logic [6:0]  TRQ_SRC_ANALOG = 7'h01;
	localparam logic [6:0]  IN_FUNC_HOME   = 7'h05;
	localparam logic [15:0] SAVE_CODE      = 16'h0001;
	localparam logic [3:0]  HT_ZERO        = 4'h1;
	localparam logic [3:0]  HT_IMMEDIATE   = 4'h2;
	localparam logic [3:0]  HT_RELEASE     = 4'h3;
	localparam logic [3:0]  HT_STOPPER     = 4'h4;

	// ********************************
	// Reset values, scaling and timing
	// ********************************
	localparam logic [15:0] SCALE_RST   = 16'h0708;
	localparam logic [15:0] ZERO16      = 16'h0000;
	localparam int          FULL_MV     = 10000;
	localparam int          CLK_NS      = 10;
	localparam int          MS_NS       = 1000000;
	localparam int          MS_CYC      = MS_NS / CLK_NS;

	typedef enum logic [2:0] {
		HS_IDLE, HS_SEEK, HS_ZERO, HS_RELEASE, HS_PUSH, HS_PRESET, HS_DONE
	} tah_home_t;

endpackage

/* core/tah_scale.sv */
// Analog input to current command scaling with offset and polarity
`timescale 1ns/1ps
module tah_scale #(
	parameter int ADC_W = 14
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rstn,
	// Operands
	input  wire logic [ADC_W-1:0]    ain_mv,
	input  wire logic [15:0]         ofs_mv,
	input  wire logic [15:0]         scale,
	input  wire logic                invert,
	// Result in 0.01 Arms
	output logic signed [15:0]       cur_ff
);
	import tah_pkg::*;

	localparam logic signed [33:0] FULL_S = 34'(FULL_MV);

	logic signed [16:0] diff;
	logic signed [33:0] prod;
	logic signed [33:0] quot;
	logic signed [15:0] nxt_cur;

	// Scale is the current at full span, so the reference level gives zero
	always_comb begin
		diff    = $signed({1'b0, 16'(ain_mv)}) - $signed({1'b0, ofs_mv});
		prod    = 34'(diff) * $signed({18'h00000, scale});
		quot    = prod / FULL_S;
		nxt_cur = invert ? -quot[15:0] : quot[15:0]; // R1 R2
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cur_ff <= 16'sh0000;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

endmodule

/* core/tah_ctrl.sv */
// Torque mode from analog input, offset calibration, parameter save and homing
`timescale 1ns/1ps
// Operation
// R1: 0 V reference, scale 1800: 5 V is 9 Arms
// R2: 5 V reference: 10 V +9, 0 V -9 Arms
// R3: Host applies zero level before offset calibration
// R4: Offset-measure bit samples input into offset
// R5: Writing 1 to save commits parameters
// R6: Analog torque mode drives current, no hold
// R7: Three origin-signal homing variants plus stopper homing
// R8: Point-zero: go to motor zero, preset
// R9: Immediate-stop: halt on origin, preset
// R10: Release: reverse until origin drops, preset
// R11: Origin from pin or from link
// R12: Home sensor assignable to any input setting
// R13: Host arms origin with command bit 13
// R14: Stopper: push for time and torque, preset
// R15: Host sets servo-on bit before motion
module tah_ctrl #(
	parameter int ADC_W      = 14,
	parameter int MS_CYCLES  = tah_pkg::MS_CYC
) (
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                rstn,
	// Parameter link
	input  wire logic                par_wr_en,
	input  wire logic                par_rd_en,
	input  wire logic [7:0]          par_id,
	input  wire logic [15:0]         par_wdata,
	output logic [15:0]              par_rdata_ff,
	// Pins
	input  wire logic [ADC_W-1:0]    ain_mv,
	input  wire logic [tah_pkg::NUM_IN-1:0] in_pins,
	input  wire logic                motor_zero,
	// Current loop
	output logic signed [15:0]       cur_cmd_ff,
	output logic                     cur_en_ff,
	output logic                     pos_hold_ff,
	// Motion and position counter
	output logic                     move_en_ff,
	output logic                     move_dir_ff,
	output logic [15:0]              move_spd_ff,
	output logic [15:0]              trq_lim_ff,
	output logic                     preset_load_ff,
	output logic [15:0]              preset_val_ff,
	output logic                     home_done_ff,
	// Retained storage
	output logic                     save_req_ff
);
	import tah_pkg::*;

	// ********************************
	// Pin synchronisers
	// ********************************
	logic [ADC_W-1:0]  ain_m_ff, ain_s_ff;
	logic [NUM_IN-1:0] pin_m_ff, pin_s_ff;
	logic              zero_m_ff, zero_s_ff, zero_d_ff;

	// Analog word is assumed quasi-static; the converter holds it between samples
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ain_m_ff  <= '0;
			ain_s_ff  <= '0;
			pin_m_ff  <= '0;
			pin_s_ff  <= '0;
			zero_m_ff <= 1'b0;
			zero_s_ff <= 1'b0;
			zero_d_ff <= 1'b0;
		end else begin
			ain_m_ff  <= ain_mv;
			ain_s_ff  <= ain_m_ff;
			pin_m_ff  <= in_pins;
			pin_s_ff  <= pin_m_ff;
			zero_m_ff <= motor_zero;
			zero_s_ff <= zero_m_ff;
			zero_d_ff <= zero_s_ff;
		end
	end

	// ********************************
	// Parameters
	// ********************************
	logic [15:0] cmd_ff, mode_ff, preset_ff, hspd_ff, cspd_ff, tms_ff, ttrq_ff;
	logic [15:0] scale_ff, ofs_ff;
	logic [7:0]  tsel_ff;
	logic [3:0]  htype_ff;
	logic        hdir_ff, meas_d_ff;
	logic [7:0]  inset_ff [NUM_IN];
	logic [15:0] nxt_cmd, nxt_mode, nxt_preset, nxt_hspd, nxt_cspd, nxt_tms, nxt_ttrq;
	logic [15:0] nxt_scale, nxt_ofs, nxt_rdata;
	logic [7:0]  nxt_tsel;
	logic [3:0]  nxt_htype;
	logic        nxt_hdir, nxt_save;
	logic [7:0]  nxt_inset [NUM_IN];
	tah_home_t   hs_ff;

	always_comb begin
		nxt_cmd    = cmd_ff;
		nxt_mode   = mode_ff;
		nxt_preset = preset_ff;
		nxt_hspd   = hspd_ff;
		nxt_cspd   = cspd_ff;
		nxt_tms    = tms_ff;
		nxt_ttrq   = ttrq_ff;
		nxt_scale  = scale_ff;
		nxt_ofs    = ofs_ff;
		nxt_tsel   = tsel_ff;
		nxt_htype  = htype_ff;
		nxt_hdir   = hdir_ff;
		nxt_save   = 1'b0;
		nxt_inset  = inset_ff;
		if (par_wr_en) begin
			case (par_id)
				PAR_SAVE:       nxt_save   = (par_wdata == SAVE_CODE); // R5
				PAR_SERVO_CMD:  nxt_cmd    = par_wdata;
				PAR_CTRL_MODE:  nxt_mode   = par_wdata;
				PAR_TRQ_SEL:    nxt_tsel   = par_wdata[7:0];
				PAR_HOME_TYPE:  nxt_htype  = par_wdata[3:0];
				PAR_PRESET:     nxt_preset = par_wdata;
				PAR_HOME_DIR:   nxt_hdir   = par_wdata[0];
				PAR_HOME_SPD:   nxt_hspd   = par_wdata;
				PAR_CREEP_SPD:  nxt_cspd   = par_wdata;
				PAR_THRUST_MS:  nxt_tms    = par_wdata;
				PAR_THRUST_TRQ: nxt_ttrq   = par_wdata;
				PAR_CUR_SCALE:  nxt_scale  = par_wdata;
				PAR_AIN_OFS:    nxt_ofs    = par_wdata;
				// Unmapped numbers are ignored
				default:        nxt_save   = 1'b0;
			endcase
			for (int i = 0; i < NUM_IN; i++) begin
				if (par_id == PAR_IN_SET0 + 8'(i)) begin
					nxt_inset[i] = par_wdata[7:0]; // R12
				end
			end
		end
		// Measurement wins over a host write in the same cycle
		if (cmd_ff[SC_OFS_MEAS] && !meas_d_ff) begin
			nxt_ofs = 16'(ain_s_ff); // R4
		end
		nxt_rdata = par_rdata_ff;
		if (par_rd_en) begin
			case (par_id)
				PAR_STATUS:     nxt_rdata = {13'h0000, hs_ff == HS_DONE,
						hs_ff != HS_IDLE, cur_en_ff};
				PAR_SERVO_CMD:  nxt_rdata = cmd_ff;
				PAR_CTRL_MODE:  nxt_rdata = mode_ff;
				PAR_TRQ_SEL:    nxt_rdata = {8'h00, tsel_ff};
				PAR_HOME_TYPE:  nxt_rdata = {12'h000, htype_ff};
				PAR_PRESET:     nxt_rdata = preset_ff;
				PAR_HOME_DIR:   nxt_rdata = {15'h0000, hdir_ff};
				PAR_HOME_SPD:   nxt_rdata = hspd_ff;
				PAR_CREEP_SPD:  nxt_rdata = cspd_ff;
				PAR_THRUST_MS:  nxt_rdata = tms_ff;
				PAR_THRUST_TRQ: nxt_rdata = ttrq_ff;
				PAR_CUR_SCALE:  nxt_rdata = scale_ff;
				PAR_AIN_OFS:    nxt_rdata = ofs_ff;
				default:        nxt_rdata = ZERO16;
			endcase
			for (int i = 0; i < NUM_IN; i++) begin
				if (par_id == PAR_IN_SET0 + 8'(i)) begin
					nxt_rdata = {8'h00, inset_ff[i]};
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cmd_ff       <= ZERO16;
			mode_ff      <= ZERO16;
			preset_ff    <= ZERO16;
			hspd_ff      <= ZERO16;
			cspd_ff      <= ZERO16;
			tms_ff       <= ZERO16;
			ttrq_ff      <= ZERO16;
			scale_ff     <= SCALE_RST;
			ofs_ff       <= ZERO16;
			tsel_ff      <= 8'h00;
			htype_ff     <= 4'h0;
			hdir_ff      <= 1'b0;
			meas_d_ff    <= 1'b0;
			save_req_ff  <= 1'b0;
			par_rdata_ff <= ZERO16;
			for (int i = 0; i < NUM_IN; i++) begin
				inset_ff[i] <= 8'h00;
			end
		end else begin
			cmd_ff       <= nxt_cmd;
			mode_ff      <= nxt_mode;
			preset_ff    <= nxt_preset;
			hspd_ff      <= nxt_hspd;
			cspd_ff      <= nxt_cspd;
			tms_ff       <= nxt_tms;
			ttrq_ff      <= nxt_ttrq;
			scale_ff     <= nxt_scale;
			ofs_ff       <= nxt_ofs;
			tsel_ff      <= nxt_tsel;
			htype_ff     <= nxt_htype;
			hdir_ff      <= nxt_hdir;
			meas_d_ff    <= cmd_ff[SC_OFS_MEAS];
			save_req_ff  <= nxt_save;
			par_rdata_ff <= nxt_rdata;
			inset_ff     <= nxt_inset;
		end
	end

	// ********************************
	// Analog torque path
	// ********************************
	logic signed [15:0] scaled;
	logic               servo_on, trq_run, home_sel;

	tah_scale #(
		.ADC_W (ADC_W)
	) u_scale (
		.clk    (clk),
		.rstn   (rstn),
		.ain_mv (ain_s_ff),
		.ofs_mv (ofs_ff),
		.scale  (scale_ff),
		.invert (tsel_ff[POL_BIT]),
		.cur_ff (scaled)
	);

	always_comb begin
		servo_on = cmd_ff[SC_SERVO_ON]; // R15
		trq_run  = servo_on && (mode_ff == MODE_TORQUE)
			&& (tsel_ff[6:0] == TRQ_SRC_ANALOG); // R6
		home_sel = servo_on && (mode_ff == MODE_HOME);
	end

	// ********************************
	// Origin detection
	// ********************************
	logic origin;

	always_comb begin
		origin = cmd_ff[SC_HOME_ARM]; // R11 R13
		for (int i = 0; i < NUM_IN; i++) begin
			if (inset_ff[i][6:0] == IN_FUNC_HOME) begin
				origin = origin | (pin_s_ff[i] ^ inset_ff[i][IN_NEG_BIT]); // R11 R12
			end
		end
	end

	// ********************************
	// Homing sequencer
	// ********************************
	localparam int MSC_W = $clog2(MS_CYCLES + 1);

	tah_home_t          nxt_hs;
	logic [MSC_W-1:0]   msc_ff, nxt_msc;
	logic [15:0]        msn_ff, nxt_msn;
	logic               nxt_move, nxt_dir, nxt_load, nxt_cur_en, nxt_hold;
	logic [15:0]        nxt_spd, nxt_trq;
	logic signed [15:0] nxt_cur;

	always_comb begin
		nxt_hs   = hs_ff;
		nxt_msc  = msc_ff;
		nxt_msn  = msn_ff;
		nxt_load = 1'b0;
		case (hs_ff)
			HS_IDLE: begin
				if (home_sel) begin
					nxt_hs  = (htype_ff == HT_STOPPER) ? HS_PUSH : HS_SEEK; // R7
					nxt_msc = '0;
					nxt_msn = ZERO16;
				end
			end
			HS_SEEK: begin
				if (origin) begin
					case (htype_ff)
						HT_ZERO:      nxt_hs = HS_ZERO; // R8
						HT_RELEASE:   nxt_hs = HS_RELEASE; // R10
						default:      nxt_hs = HS_PRESET; // R9
					endcase
				end
			end
			HS_ZERO: begin
				if (zero_s_ff && !zero_d_ff) begin
					nxt_hs = HS_PRESET; // R8
				end
			end
			HS_RELEASE: begin
				if (!origin) begin
					nxt_hs = HS_PRESET; // R10
				end
			end
			HS_PUSH: begin
				// Thrust time counted in whole milliseconds
				if (msn_ff >= tms_ff) begin
					nxt_hs = HS_PRESET; // R14
				end else if (msc_ff == MSC_W'(MS_CYCLES - 1)) begin
					nxt_msc = '0;
					nxt_msn = msn_ff + 16'h0001;
				end else begin
					nxt_msc = msc_ff + MSC_W'(1);
				end
			end
			HS_PRESET: begin
				nxt_load = 1'b1; // R8 R9 R10 R14
				nxt_hs   = HS_DONE;
			end
			HS_DONE: begin
				nxt_hs = HS_DONE;
			end
			default: nxt_hs = HS_IDLE;
		endcase
		// Dropping servo-on or leaving homing mode aborts the sequence
		if (!home_sel) begin
			nxt_hs = HS_IDLE;
		end
		nxt_move = (nxt_hs == HS_SEEK) || (nxt_hs == HS_ZERO)
			|| (nxt_hs == HS_RELEASE) || (nxt_hs == HS_PUSH);
		nxt_dir  = (nxt_hs == HS_RELEASE) ? !hdir_ff : hdir_ff; // R10
		nxt_spd  = ((nxt_hs == HS_ZERO) || (nxt_hs == HS_RELEASE)) ? cspd_ff : hspd_ff;
		nxt_spd  = nxt_move ? nxt_spd : ZERO16; // R9
		nxt_trq  = (nxt_hs == HS_PUSH) ? ttrq_ff : ZERO16; // R14
		nxt_cur_en = trq_run; // R6
		nxt_cur    = trq_run ? scaled : 16'sh0000; // R6
		nxt_hold   = servo_on && !trq_run && !nxt_move; // R6
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hs_ff          <= HS_IDLE;
			msc_ff         <= '0;
			msn_ff         <= ZERO16;
			move_en_ff     <= 1'b0;
			move_dir_ff    <= 1'b0;
			move_spd_ff    <= ZERO16;
			trq_lim_ff     <= ZERO16;
			preset_load_ff <= 1'b0;
			preset_val_ff  <= ZERO16;
			home_done_ff   <= 1'b0;
			cur_en_ff      <= 1'b0;
			cur_cmd_ff     <= 16'sh0000;
			pos_hold_ff    <= 1'b0;
		end else begin
			hs_ff          <= nxt_hs;
			msc_ff         <= nxt_msc;
			msn_ff         <= nxt_msn;
			move_en_ff     <= nxt_move;
			move_dir_ff    <= nxt_dir;
			move_spd_ff    <= nxt_spd;
			trq_lim_ff     <= nxt_trq;
			preset_load_ff <= nxt_load;
			preset_val_ff  <= preset_ff;
			home_done_ff   <= (nxt_hs == HS_DONE);
			cur_en_ff      <= nxt_cur_en;
			cur_cmd_ff     <= nxt_cur;
			pos_hold_ff    <= nxt_hold;
		end
	end

endmodule

/* verif/tah_host_model.sv */
// Host controller model driving the parameter link
`timescale 1ns/1ps
module tah_host_model (
	// Clock
	input	wire logic	clk,
	// Parameter link
	output	logic		par_wr_en,
	output	logic		par_rd_en,
	output	logic [7:0]	par_id,
	output	logic [15:0]	par_wdata
);
	import tah_pkg::*;
	initial begin
		par_wr_en = 1'b0;
		par_rd_en = 1'b0;
		par_id = 8'h00;
		par_wdata = 16'h0000;
	end
	// Idle id and data are inverted so nothing can lean on stale values
	task automatic xfer(input logic w, input logic [7:0] id, input logic [15:0] d);
		@(negedge clk);
		par_wr_en = w;
		par_rd_en = !w;
		par_id = id;
		par_wdata = d;
		@(negedge clk);
		par_wr_en = 1'b0;
		par_rd_en = 1'b0;
		par_id = ~id;
		par_wdata = ~d;
	endtask
endmodule

/* verif/tah_ctrl_checker.sv */
// Port checker for the drive control block
`timescale 1ns/1ps
module tah_ctrl_checker #(
	parameter int ADC_W	= 14,
	parameter int MS_CYCLES	= 10
) (
	// Clock and reset
	input	wire logic			clk,
	input	wire logic			rstn,
	// Parameter link
	input	wire logic			par_wr_en,
	input	wire logic			par_rd_en,
	input	wire logic [7:0]		par_id,
	input	wire logic [15:0]		par_wdata,
	input	wire logic [15:0]		par_rdata_ff,
	// Pins
	input	wire logic [ADC_W-1:0]	ain_mv,
	input	wire logic [tah_pkg::NUM_IN-1:0]	in_pins,
	input	wire logic			motor_zero,
	// Outputs
	input	wire logic signed [15:0]	cur_cmd_ff,
	input	wire logic			cur_en_ff,
	input	wire logic			pos_hold_ff,
	input	wire logic			move_en_ff,
	input	wire logic			move_dir_ff,
	input	wire logic [15:0]		move_spd_ff,
	input	wire logic [15:0]		trq_lim_ff,
	input	wire logic			preset_load_ff,
	input	wire logic [15:0]		preset_val_ff,
	input	wire logic			home_done_ff,
	input	wire logic			save_req_ff
);
	import tah_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_save;
		par_wr_en && par_id == PAR_SAVE && par_wdata == SAVE_CODE |=> save_req_ff;
	endproperty
	a_save: assert property (p_save) else $error("save pulse missing");
	property p_save_src;
		save_req_ff |-> $past(par_wr_en) && $past(par_id) == PAR_SAVE
			&& $past(par_wdata) == SAVE_CODE;
	endproperty
	a_save_src: assert property (p_save_src) else $error("stray save pulse");
	property p_no_hold;
		cur_en_ff |-> !pos_hold_ff && !move_en_ff;
	endproperty
	a_no_hold: assert property (p_no_hold) else $error("shaft held in torque run");
	property p_cur_idle;
		!cur_en_ff [*3] |-> cur_cmd_ff == 16'sh0000;
	endproperty
	a_cur_idle: assert property (p_cur_idle) else $error("current outside torque run");
	property p_preset_once;
		preset_load_ff |=> !preset_load_ff;
	endproperty
	a_preset_once: assert property (p_preset_once) else $error("preset pulse too long");
	property p_preset_halt;
		preset_load_ff |-> home_done_ff && !move_en_ff && move_spd_ff == 16'h0000;
	endproperty
	a_preset_halt: assert property (p_preset_halt) else $error("preset while moving");
	property p_trq_push;
		trq_lim_ff != 16'h0000 |-> move_en_ff && !home_done_ff;
	endproperty
	a_trq_push: assert property (p_trq_push) else $error("thrust outside push");
	property p_spd_idle;
		!move_en_ff |-> move_spd_ff == 16'h0000;
	endproperty
	a_spd_idle: assert property (p_spd_idle) else $error("speed without motion");
	property p_done_still;
		home_done_ff |-> !move_en_ff && $past(!move_en_ff);
	endproperty
	a_done_still: assert property (p_done_still) else $error("motion after homing");
endmodule
bind tah_ctrl tah_ctrl_checker #(.ADC_W(ADC_W), .MS_CYCLES(MS_CYCLES)) chk (
	.clk(clk), .rstn(rstn), .par_wr_en(par_wr_en), .par_rd_en(par_rd_en),
	.par_id(par_id), .par_wdata(par_wdata), .par_rdata_ff(par_rdata_ff),
	.ain_mv(ain_mv), .in_pins(in_pins), .motor_zero(motor_zero),
	.cur_cmd_ff(cur_cmd_ff), .cur_en_ff(cur_en_ff), .pos_hold_ff(pos_hold_ff),
	.move_en_ff(move_en_ff), .move_dir_ff(move_dir_ff), .move_spd_ff(move_spd_ff),
	.trq_lim_ff(trq_lim_ff), .preset_load_ff(preset_load_ff),
	.preset_val_ff(preset_val_ff), .home_done_ff(home_done_ff), .save_req_ff(save_req_ff));

/* verif/tah_ctrl_test.sv */
// Self-checking bench for the drive control block
`timescale 1ns/1ps
module tah_ctrl_test;
	import tah_pkg::*;
	typedef struct {
		logic [2:0]	s;
		logic [15:0]	v;
	} tah_note_t;
	logic			clk = 1'b0;
	logic			rstn, peek, mzero;
	logic [13:0]		ain;
	logic [5:0]		pins;
	logic			wr_en, rd_en, save, cen, hold, men, mdir, pld, done;
	logic [7:0]		pid;
	logic [15:0]		wdata, rdata, spd, trq, pval;
	logic signed [15:0]	cur;
	tah_note_t		notes[$];
	tah_note_t		nt;
	int			errors = 0;
	int			comparisons = 0;
	int			seed = 55135;
	int			cyc = 0;
	int			a, k, t, n;
	always #5 clk = ~clk;
	tah_host_model host (.clk(clk), .par_wr_en(wr_en), .par_rd_en(rd_en), .par_id(pid),
		.par_wdata(wdata));
	tah_ctrl #(.ADC_W(14), .MS_CYCLES(10)) uut (
		.clk(clk), .rstn(rstn), .par_wr_en(wr_en), .par_rd_en(rd_en), .par_id(pid),
		.par_wdata(wdata), .par_rdata_ff(rdata), .ain_mv(ain), .in_pins(pins),
		.motor_zero(mzero), .cur_cmd_ff(cur), .cur_en_ff(cen), .pos_hold_ff(hold),
		.move_en_ff(men), .move_dir_ff(mdir), .move_spd_ff(spd), .trq_lim_ff(trq),
		.preset_load_ff(pld), .preset_val_ff(pval), .home_done_ff(done),
		.save_req_ff(save));
	// ********************************
	// Tasks
	// ********************************
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [15:0] obs(input logic [2:0] s);
		case (s)
			3'h0: return rdata;
			3'h1: return cur;
			3'h2: return pval;
			3'h3: return {12'h000, men, done, cen, hold};
			3'h4: return trq;
			3'h5: return spd;
			default: return {15'h0000, mdir};
		endcase
	endfunction
	task automatic wr(input logic [7:0] id, input logic [15:0] d);
		host.xfer(1'b1, id, d);
	endtask
	task automatic rd(input logic [7:0] id, input logic [15:0] exp);
		notes.push_back('{3'h0, exp});
		host.xfer(1'b0, id, 16'h0000);
	endtask
	task automatic look(input logic [2:0] s, input logic [15:0] exp);
		@(negedge clk);
		notes.push_back('{s, exp});
		peek = 1'b1;
		@(negedge clk);
		peek = 1'b0;
	endtask
	// Expected current uses the reset scale; the settle wait covers sync plus scaling
	task automatic run(input int av, input int ofs, input logic neg);
		int e;
		ain = 14'(av);
		repeat (8) @(negedge clk);
		e = (av - ofs) * int'(SCALE_RST) / FULL_MV;
		look(3'h1, neg ? 16'(-e) : 16'(e));
	endtask
	task automatic wait_done();
		n = 0;
		while (done !== 1'b1 && n < 500) begin
			@(negedge clk);
			n++;
		end
	endtask
	always @(posedge clk) begin
		#1;
		if ((rd_en === 1'b1 || peek) && notes.size() > 0) begin
			nt = notes.pop_front();
			check(obs(nt.s), nt.v);
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			errors++;
			print_verdict();
		end
	end
	// ********************************
	// Main sequence
	// ********************************
	initial begin
		rstn = 1'b0;
		peek = 1'b0;
		mzero = 1'b0;
		ain = 14'h0000;
		pins = 6'h00;
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		rd(PAR_CUR_SCALE, SCALE_RST);
		rd(8'hFF, ZERO16);
		wr(PAR_SAVE, SAVE_CODE);
		wr(PAR_CTRL_MODE, MODE_TORQUE);
		wr(PAR_TRQ_SEL, 16'h0001);
		wr(PAR_SERVO_CMD, 16'h0001);
		run(FULL_MV / 2, 0, 1'b0);
		for (int i = 0; i < 5; i++) begin
			a = ($random(seed) & 32'h7FFFFFFF) % (FULL_MV + 1);
			run(a, 0, 1'b0);
		end
		wr(PAR_AIN_OFS, 16'h1388);
		run(FULL_MV, FULL_MV / 2, 1'b0);
		run(0, FULL_MV / 2, 1'b0);
		wr(PAR_TRQ_SEL, 16'h0081);
		run(FULL_MV, FULL_MV / 2, 1'b1);
		wr(PAR_TRQ_SEL, 16'h0001);
		ain = 14'h0BB8;
		repeat (4) @(negedge clk);
		wr(PAR_SERVO_CMD, 16'h0011);
		repeat (3) @(negedge clk);
		rd(PAR_AIN_OFS, 16'h0BB8);
		run(FULL_MV * 7 / 10, FULL_MV * 3 / 10, 1'b0);
		look(3'h3, 16'h0002);
		wr(PAR_SERVO_CMD, 16'h0000);
		look(3'h3, 16'h0000);
		look(3'h1, 16'h0000);
		wr(PAR_PRESET, 16'h1234);
		wr(PAR_HOME_SPD, 16'h0064);
		wr(PAR_CREEP_SPD, 16'h000A);
		wr(PAR_THRUST_MS, 16'h0002);
		wr(PAR_THRUST_TRQ, 16'h0050);
		wr(PAR_HOME_DIR, 16'h0000);
		k = ($random(seed) & 32'h7FFFFFFF) % NUM_IN;
		wr(8'(PAR_IN_SET0 + k), 16'(IN_FUNC_HOME));
		wr(PAR_CTRL_MODE, MODE_HOME);
		for (t = 1; t <= 4; t++) begin
			wr(PAR_HOME_TYPE, 16'(t));
			wr(PAR_SERVO_CMD, 16'h0001);
			repeat (4) @(negedge clk);
			look(3'h3, 16'h0008);
			if (t == 4) look(3'h4, 16'h0050);
			if (t == 2) look(3'h5, 16'h0064);
			if (t == 3) begin
				pins[k] = 1'b1;
				repeat (6) @(negedge clk);
				look(3'h6, 16'h0001);
				pins = 6'h00;
			end else if (t < 3) begin
				wr(PAR_SERVO_CMD, 16'h2001);
				if (t == 1) begin
					repeat (6) @(negedge clk);
					look(3'h5, 16'h000A);
					mzero = 1'b1;
					repeat (4) @(negedge clk);
					mzero = 1'b0;
				end
			end
			wait_done();
			look(3'h2, 16'h1234);
			look(3'h3, 16'h0005);
			wr(PAR_SERVO_CMD, 16'h0000);
		end
		print_verdict();
	end
endmodule
